// [rtl/sdrci_consts.svh]
`ifndef SDRCI_CONSTS_SVH
`define SDRCI_CONSTS_SVH

// Command codes on {row strobe, column strobe, write enable}, all active low
`define SDRCI_CMD_LMR 3'h0
`define SDRCI_CMD_REF 3'h1
`define SDRCI_CMD_PRE 3'h2
`define SDRCI_CMD_ACT 3'h3
`define SDRCI_CMD_WR  3'h4
`define SDRCI_CMD_RD  3'h5
`define SDRCI_CMD_BST 3'h6
`define SDRCI_CMD_NOP 3'h7

// Array geometry
`define SDRCI_BANK_W 2
`define SDRCI_ROW_W  12
`define SDRCI_COL_W  9
`define SDRCI_DATA_W 16
`define SDRCI_LANES  2

// Address line carrying the precharge flag
`define SDRCI_PRECHARGE_FLAG_LINE 10

// Mode register field positions
`define SDRCI_BURST_LENGTH_LSB  0
`define SDRCI_BURST_TYPE_BIT    3
`define SDRCI_READ_LATENCY_LSB  4
`define SDRCI_WRITE_BURST_BIT   9
`define SDRCI_BL_FULL_PAGE      3'h7
`define SDRCI_CL_THREE          3'h3
`define SDRCI_MODE_RESET        12'h000

// Bank-select codes during mode-register load
`define SDRCI_SEL_MODE_REG      2'h0
`define SDRCI_SEL_EXT_MODE_REG  2'h2

// Self-timed precharge time
`define SDRCI_CLK_NS    10
`define SDRCI_PRE_NS    20
`define SDRCI_PRE_W     3
`define SDRCI_PRE_CYC   ((`SDRCI_PRE_NS + `SDRCI_CLK_NS - 1) / `SDRCI_CLK_NS)

`endif

// [rtl/sdrci_pkg.sv]
package sdrci_pkg;
`include "sdrci_consts.svh"

    // Clock-gating states
    typedef enum logic [3:0] {
        PW_RUN  = 4'h1,
        PW_PDN  = 4'h2,
        PW_SREF = 4'h4,
        PW_DPD  = 4'h8
    } sdrci_pwr_e;

    typedef logic [`SDRCI_BANK_W-1:0] sdrci_bank_t;
    typedef logic [`SDRCI_ROW_W-1:0]  sdrci_row_t;
    typedef logic [`SDRCI_COL_W-1:0]  sdrci_col_t;
    typedef logic [`SDRCI_DATA_W-1:0] sdrci_data_t;

    // Whole state of the command interface
    typedef struct packed {
        sdrci_pwr_e                      pwr;
        logic                            ckeQ;
        logic [3:0]                      bankOpen;
        logic [3:0][`SDRCI_ROW_W-1:0]    rowAddr;
        logic [3:0][`SDRCI_PRE_W-1:0]    preCnt;
        logic                            bActive;
        logic                            bWrite;
        logic                            bAp;
        logic                            bFull;
        sdrci_bank_t                     bBank;
        sdrci_col_t                      bStart;
        sdrci_col_t                      bCnt;
        sdrci_col_t                      bLenM1;
        logic [`SDRCI_ROW_W-1:0]         mode;
        logic [`SDRCI_ROW_W-1:0]         ext;
        logic                            rdV0;
        logic                            rdV1;
        logic                            rdV2;
        logic [`SDRCI_LANES-1:0]         maskQ1;
        logic [`SDRCI_LANES-1:0]         maskQ2;
        sdrci_data_t                     rdStage;
        sdrci_data_t                     rdStage2;
        sdrci_data_t                     dOut;
        logic [`SDRCI_LANES-1:0]         dOe;
    } sdrci_state_s;

endpackage

// [rtl/sdrci_mem.sv]
`timescale 1ns/1ps
`include "sdrci_consts.svh"

// Byte-lane storage array with registered read data
module sdrci_mem #(
    parameter int AW = 23
) (
    input  wire logic                            clk_sys,
    input  wire logic                            en,
    input  wire logic                            we,
    input  wire logic [`SDRCI_LANES-1:0]         be,
    input  wire logic [AW-1:0]                   addr,
    input  wire logic [`SDRCI_DATA_W-1:0]        wdata,
    output wire logic [`SDRCI_DATA_W-1:0]        rdata
);

    // One array per byte lane so masked lanes stay untouched
    for (genvar g = 0; g < `SDRCI_LANES; g++) begin : gLane
        logic [7:0] laneMem [0:(1<<AW)-1];
        logic [7:0] laneRd_r;

        // Lane write when enabled with write set, otherwise registered read while enabled
        always_ff @(posedge clk_sys) begin
            if (en) begin
                if (we) begin
                    if (be[g]) begin
                        laneMem[addr] <= wdata[8*g +: 8];
                    end
                end else begin
                    laneRd_r <= laneMem[addr];
                end
            end
        end

        assign rdata[8*g +: 8] = laneRd_r;
    end

endmodule

// [rtl/sdrci_core.sv]
`timescale 1ns/1ps
`include "sdrci_consts.svh"

module sdrci_core #(
    parameter int MEM_ROW_W = 12
) (
    input  wire logic                            clk_sys,
    input  wire logic                            rstn,
    input  wire logic                            clkEnable,
    input  wire logic                            chipSelectN,
    input  wire logic                            rowStrobeN,
    input  wire logic                            colStrobeN,
    input  wire logic                            writeEnableN,
    input  wire sdrci_pkg::sdrci_bank_t          bankSelect,
    input  wire sdrci_pkg::sdrci_row_t           addressIn,
    input  wire logic                            lowerByteMask,
    input  wire logic                            upperByteMask,
    input  wire sdrci_pkg::sdrci_data_t          dataIoIn,
    output wire sdrci_pkg::sdrci_data_t          dataIoOut,
    output wire logic [1:0]                      dataIoOe,
    output wire logic [3:0]                      bankOpen,
    output wire logic [11:0]                     modeReg,
    output wire logic [11:0]                     extModeReg,
    output wire sdrci_pkg::sdrci_pwr_e           powerState
);
    import sdrci_pkg::*;

    localparam int MEM_AW = `SDRCI_BANK_W + MEM_ROW_W + `SDRCI_COL_W;
    localparam sdrci_state_s ST_RST = '{pwr: PW_RUN, ckeQ: 1'b1, mode: `SDRCI_MODE_RESET,
                                        ext: `SDRCI_MODE_RESET, default: '0};

    sdrci_state_s            s_r;
    sdrci_state_s            s_nxt;
    logic                    memEn;
    logic                    memWe;
    logic [1:0]              memBe;
    sdrci_bank_t             memBank;
    sdrci_row_t              memRow;
    sdrci_col_t              memCol;
    logic [MEM_AW-1:0]       memAddr;
    sdrci_data_t             memRdata;
    logic [2:0]              cmd;
    logic [1:0]              maskNow;
    logic                    cl3;
    logic                    il;
    sdrci_col_t              blMask;
    sdrci_col_t              nxtCnt;
    logic                    outV;
    logic                    allIdle;

    // Column within the burst block, sequential or interleaved
    function automatic sdrci_col_t colOf(sdrci_col_t start, sdrci_col_t cnt, sdrci_col_t msk, logic ilv);
        sdrci_col_t off;
        off = ilv ? (start ^ cnt) : sdrci_col_t'(start + cnt);
        return (start & ~msk) | (off & msk);
    endfunction

    // Burst length code to column mask
    function automatic sdrci_col_t maskOf(logic [2:0] code);
        sdrci_col_t m;
        case (code)
            3'h0:               m = 9'h000;
            3'h1:               m = 9'h001;
            3'h2:               m = 9'h003;
            3'h3:               m = 9'h007;
            `SDRCI_BL_FULL_PAGE: m = 9'h1FF;
            default:            m = 9'h000;
        endcase
        return m;
    endfunction

    // Close a bank and start its precharge timer
    function automatic sdrci_state_s closeBank(sdrci_state_s st, sdrci_bank_t b);
        st.bankOpen[b] = 1'b0;
        st.preCnt[b]   = `SDRCI_PRE_W'(`SDRCI_PRE_CYC);
        if (st.bActive && st.bBank == b) begin
            st.bActive = 1'b0;
        end
        return st;
    endfunction

    assign cl3    = s_r.mode[`SDRCI_READ_LATENCY_LSB +: 3] == `SDRCI_CL_THREE;
    assign il     = s_r.mode[`SDRCI_BURST_TYPE_BIT];
    assign blMask = maskOf(s_r.mode[`SDRCI_BURST_LENGTH_LSB +: 3]);
    assign maskNow = {upperByteMask, lowerByteMask};
    assign allIdle = (s_r.bankOpen == 4'h0) && !s_r.bActive;
    assign cmd = chipSelectN ? `SDRCI_CMD_NOP : {rowStrobeN, colStrobeN, writeEnableN};

    // Next-state logic
    always_comb begin
        s_nxt   = s_r;
        memEn   = 1'b0;
        memWe   = 1'b0;
        memBe   = 2'h0;
        memBank = '0;
        memRow  = '0;
        memCol  = '0;
        nxtCnt  = sdrci_col_t'(s_r.bCnt + 9'h001);
        outV    = cl3 ? s_r.rdV2 : s_r.rdV1;
        s_nxt.ckeQ = clkEnable;
        case (s_r.pwr)
            PW_RUN: begin
                // clock suspend freezes everything while the enable was low
                if (s_r.ckeQ) begin
                    s_nxt.maskQ1  = maskNow;
                    s_nxt.maskQ2  = s_r.maskQ1;
                    s_nxt.rdV0    = 1'b0;
                    s_nxt.rdV1    = s_r.rdV0;
                    s_nxt.rdV2    = s_r.rdV1;
                    s_nxt.rdStage  = memRdata;
                    s_nxt.rdStage2 = s_r.rdStage;
                    // Word leaves the pins in step with its lane enable
                    s_nxt.dOut     = cl3 ? s_r.rdStage2 : s_r.rdStage;
                    s_nxt.dOe     = {2{outV}} & ~s_r.maskQ2;
                    for (int b = 0; b < 4; b++) begin
                        if (s_r.preCnt[b] != '0) begin
                            s_nxt.preCnt[b] = s_r.preCnt[b] - `SDRCI_PRE_W'(1);
                        end
                    end
                    if (s_r.bActive) begin
                        memEn        = 1'b1;
                        memWe        = s_r.bWrite;
                        memBe        = ~maskNow;
                        memBank      = s_r.bBank;
                        memRow       = s_r.rowAddr[s_r.bBank];
                        memCol       = colOf(s_r.bStart, nxtCnt, s_r.bLenM1, il);
                        s_nxt.bCnt   = nxtCnt;
                        if (!s_r.bFull && nxtCnt == s_r.bLenM1) begin
                            s_nxt.bActive = 1'b0;
                            if (s_r.bAp) begin
                                s_nxt = closeBank(s_nxt, s_r.bBank);
                            end
                        end
                    end
                    case (cmd)
                        `SDRCI_CMD_ACT: begin
                            if (!s_r.bankOpen[bankSelect] && s_r.preCnt[bankSelect] == '0) begin
                                s_nxt.bankOpen[bankSelect] = 1'b1;
                                s_nxt.rowAddr[bankSelect]  = addressIn;
                            end
                        end
                        `SDRCI_CMD_RD, `SDRCI_CMD_WR: begin
                            if (s_r.bankOpen[bankSelect]) begin
                                // new column interrupts the running burst
                                if (s_r.bActive && s_r.bAp && s_r.bBank != bankSelect) begin
                                    s_nxt = closeBank(s_nxt, s_r.bBank);
                                end
                                memEn         = 1'b1;
                                memWe         = cmd == `SDRCI_CMD_WR;
                                memBe         = ~maskNow;
                                memBank       = bankSelect;
                                memRow        = s_r.rowAddr[bankSelect];
                                memCol        = addressIn[`SDRCI_COL_W-1:0];
                                s_nxt.bBank   = bankSelect;
                                s_nxt.bStart  = addressIn[`SDRCI_COL_W-1:0];
                                s_nxt.bCnt    = '0;
                                s_nxt.bWrite  = memWe;
                                s_nxt.bAp     = addressIn[`SDRCI_PRECHARGE_FLAG_LINE];
                                if (memWe && s_r.mode[`SDRCI_WRITE_BURST_BIT]) begin
                                    s_nxt.bLenM1 = '0;
                                    s_nxt.bFull  = 1'b0;
                                end else begin
                                    s_nxt.bLenM1 = blMask;
                                    s_nxt.bFull  = s_r.mode[`SDRCI_BURST_LENGTH_LSB +: 3] == `SDRCI_BL_FULL_PAGE;
                                end
                                s_nxt.bActive = (s_nxt.bLenM1 != '0) || s_nxt.bFull;
                                if (!s_nxt.bActive && s_nxt.bAp) begin
                                    s_nxt = closeBank(s_nxt, bankSelect);
                                end
                            end
                        end
                        `SDRCI_CMD_BST: begin
                            s_nxt.bActive = 1'b0;
                        end
                        `SDRCI_CMD_PRE: begin
                            for (int b = 0; b < 4; b++) begin
                                if ((addressIn[`SDRCI_PRECHARGE_FLAG_LINE] || bankSelect == b[1:0])
                                    && s_r.bankOpen[b]) begin
                                    s_nxt = closeBank(s_nxt, b[1:0]);
                                end
                            end
                        end
                        `SDRCI_CMD_LMR: begin
                            if (allIdle && bankSelect == `SDRCI_SEL_MODE_REG) begin
                                s_nxt.mode = addressIn;
                            end else if (allIdle && bankSelect == `SDRCI_SEL_EXT_MODE_REG) begin
                                s_nxt.ext = addressIn;
                            end
                        end
                        default: begin
                        end
                    endcase
                    s_nxt.rdV0 = memEn && !memWe;
                    // low-power entry when no burst runs
                    if (!clkEnable && !s_r.bActive) begin
                        if (allIdle && cmd == `SDRCI_CMD_REF) begin
                            s_nxt.pwr = PW_SREF;
                        end else if (allIdle && cmd == `SDRCI_CMD_BST) begin
                            s_nxt.pwr = PW_DPD;
                        end else begin
                            s_nxt.pwr = PW_PDN;
                        end
                    end
                end
            end
            PW_PDN, PW_SREF, PW_DPD: begin
                // only the return of the enable is watched
                s_nxt.dOe = 2'h0;
                if (clkEnable) begin
                    s_nxt.pwr = PW_RUN;
                end
            end
            default: begin
                s_nxt.pwr = PW_RUN;
            end
        endcase
    end

    // single rising-edge capture of all state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // bank, row, column addressing of the array
    assign memAddr = {memBank, memRow[MEM_ROW_W-1:0], memCol};

    sdrci_mem #(
        .AW      (MEM_AW)
    ) uMem (
        .clk_sys (clk_sys),
        .en      (memEn),
        .we      (memWe),
        .be      (memBe),
        .addr    (memAddr),
        .wdata   (dataIoIn),
        .rdata   (memRdata)
    );

    // Outputs straight from the state register
    assign dataIoOut  = s_r.dOut;
    assign dataIoOe   = s_r.dOe;
    assign bankOpen   = s_r.bankOpen;
    assign modeReg    = s_r.mode;
    assign extModeReg = s_r.ext;
    assign powerState = s_r.pwr;

endmodule

// [dv/sdrci_core_sva.sv]
`timescale 1ns/1ps
`include "sdrci_consts.svh"

// Port-level checks of the command interface
module sdrci_core_sva (
    input wire logic                   clk_sys,
    input wire logic                   rstn,
    input wire logic                   clkEnable,
    input wire logic                   chipSelectN,
    input wire logic                   rowStrobeN,
    input wire logic                   colStrobeN,
    input wire logic                   writeEnableN,
    input wire sdrci_pkg::sdrci_bank_t bankSelect,
    input wire sdrci_pkg::sdrci_row_t  addressIn,
    input wire logic                   lowerByteMask,
    input wire logic                   upperByteMask,
    input wire sdrci_pkg::sdrci_data_t dataIoIn,
    input wire sdrci_pkg::sdrci_data_t dataIoOut,
    input wire logic [1:0]             dataIoOe,
    input wire logic [3:0]             bankOpen,
    input wire logic [11:0]            modeReg,
    input wire logic [11:0]            extModeReg,
    input wire sdrci_pkg::sdrci_pwr_e  powerState
);
    import sdrci_pkg::*;
    logic       ckeD_r;
    logic [2:0] cmdCode;
    logic       take;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // Clock enable history as the decoder sees it
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ckeD_r <= 1'b1;
        end else begin
            ckeD_r <= clkEnable;
        end
    end

    // Decoded command and its acceptance
    assign cmdCode = {rowStrobeN, colStrobeN, writeEnableN};
    assign take    = !chipSelectN && ckeD_r && (powerState == PW_RUN);

    a_mode_take: assert property (
        take && cmdCode == `SDRCI_CMD_LMR && bankSelect == `SDRCI_SEL_MODE_REG && bankOpen == 4'h0
        |=> modeReg == $past(addressIn)) else $error("mode register not loaded");
    a_ext_load: assert property (
        $changed(extModeReg) |-> $past(take && cmdCode == `SDRCI_CMD_LMR && bankSelect == `SDRCI_SEL_EXT_MODE_REG)
        && extModeReg == $past(addressIn)) else $error("extended register changed wrongly");
    a_cs_ignore: assert property (
        chipSelectN |=> $stable(modeReg) && (bankOpen & ~$past(bankOpen)) == 4'h0)
        else $error("command acted with chip select high");
    a_act_open: assert property (
        (bankOpen & ~$past(bankOpen)) != 4'h0 |-> $past(take && cmdCode == `SDRCI_CMD_ACT)
        && (bankOpen & ~$past(bankOpen)) == (4'h1 << $past(bankSelect))) else $error("bank opened without activate");
    a_pre_all: assert property (
        take && cmdCode == `SDRCI_CMD_PRE && addressIn[10] |=> bankOpen == 4'h0)
        else $error("precharge all left a bank open");
    a_pre_one: assert property (
        take && cmdCode == `SDRCI_CMD_PRE && !addressIn[10] |=> !bankOpen[$past(bankSelect)])
        else $error("precharge left its bank open");
    a_read_latency: assert property (
        take && cmdCode == `SDRCI_CMD_RD && bankOpen[bankSelect] && modeReg[6:4] != 3'h3
        && !lowerByteMask && !upperByteMask |-> ##3 dataIoOe == 2'h3) else $error("read word not driven");
    a_mask_float: assert property (
        (dataIoOe & $past({upperByteMask, lowerByteMask}, 3)) == 2'h0) else $error("masked lane driven");
    a_pwr_enter: assert property (
        powerState != PW_RUN && $past(powerState) == PW_RUN |-> !$past(clkEnable))
        else $error("low power entered with clock enable high");
    a_pwr_exit: assert property (
        $past(powerState) != PW_RUN && $past(clkEnable) |-> powerState == PW_RUN)
        else $error("low power not left");
    a_sref_entry: assert property (
        take && !clkEnable && cmdCode == `SDRCI_CMD_REF && bankOpen == 4'h0 |=> powerState == PW_SREF)
        else $error("self refresh not entered");
    a_dpd_entry: assert property (
        take && !clkEnable && cmdCode == `SDRCI_CMD_BST && bankOpen == 4'h0 |=> powerState == PW_DPD)
        else $error("deep power-down not entered");

    // Main scenarios reached
    c_read: cover property (take && cmdCode == `SDRCI_CMD_RD);
    c_sref: cover property (powerState == PW_SREF);
    c_lane: cover property (dataIoOe == 2'h1);
endmodule

bind sdrci_core sdrci_core_sva u_sva (.clk_sys, .rstn, .clkEnable, .chipSelectN, .rowStrobeN, .colStrobeN,
    .writeEnableN, .bankSelect, .addressIn, .lowerByteMask, .upperByteMask, .dataIoIn, .dataIoOut, .dataIoOe,
    .bankOpen, .modeReg, .extModeReg, .powerState);

// [dv/sdrci_ctrl_model.sv]
`timescale 1ns/1ps

// Behavioural memory controller on the command pins
module sdrci_ctrl_model (
    input  wire logic                   clk_sys,
    input  wire sdrci_pkg::sdrci_data_t dataIoOut,
    input  wire logic [1:0]             dataIoOe,
    output logic                        clkEnable,
    output logic                        chipSelectN,
    output logic                        rowStrobeN,
    output logic                        colStrobeN,
    output logic                        writeEnableN,
    output sdrci_pkg::sdrci_bank_t      bankSelect,
    output sdrci_pkg::sdrci_row_t       addressIn,
    output logic                        lowerByteMask,
    output logic                        upperByteMask,
    output sdrci_pkg::sdrci_data_t      dataIoIn
);
    import sdrci_pkg::*;
    sdrci_data_t dqDrive;
    sdrci_data_t floatPat;
    logic        drvOn;

    // Idle levels at time zero
    initial begin
        {clkEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 5'h1F;
        {bankSelect, addressIn, lowerByteMask, upperByteMask} = '0;
        dqDrive = 16'h0000;
        drvOn = 1'b0;
        floatPat = 16'h5AA5;
    end

    // Undriven bus shows a changing pattern
    always @(posedge clk_sys) begin
        floatPat <= ~floatPat;
    end

    // Wire level per lane from both drivers
    assign dataIoIn[7:0]  = dataIoOe[0] ? dataIoOut[7:0] : (drvOn ? dqDrive[7:0] : floatPat[7:0]);
    assign dataIoIn[15:8] = dataIoOe[1] ? dataIoOut[15:8] : (drvOn ? dqDrive[15:8] : floatPat[15:8]);

    task automatic cmd(input logic [2:0] c, input sdrci_bank_t ba = 2'h0, input sdrci_row_t a = 12'h000,
                       input sdrci_data_t d = 16'h0000, input logic dv = 1'b0, input logic [1:0] m = 2'h0,
                       input logic k = 1'b1, input logic cs = 1'b0);
        @(posedge clk_sys);
        chipSelectN <= cs;
        {rowStrobeN, colStrobeN, writeEnableN} <= c;
        bankSelect <= ba;
        addressIn <= a;
        dqDrive <= d;
        drvOn <= dv;
        {upperByteMask, lowerByteMask} <= m;
        clkEnable <= k;
    endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps
`include "sdrci_consts.svh"

module tb;
    import sdrci_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    int          error_cnt = 0;
    int          checked = 0;
    logic [15:0] expMem [4][8];
    logic [2:0]  pwrCmd [3] = '{`SDRCI_CMD_NOP, `SDRCI_CMD_REF, `SDRCI_CMD_BST};
    sdrci_pwr_e  pwrExp [3] = '{PW_PDN, PW_SREF, PW_DPD};
    wire logic   clkEnable, chipSelectN, rowStrobeN, colStrobeN, writeEnableN, lowerByteMask, upperByteMask;
    wire sdrci_bank_t bankSelect;
    wire sdrci_row_t  addressIn;
    wire sdrci_data_t dataIoIn, dataIoOut;
    wire logic [1:0]  dataIoOe;
    wire logic [3:0]  bankOpen;
    wire logic [11:0] modeReg, extModeReg;
    wire sdrci_pwr_e  powerState;

    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;

    sdrci_core #(.MEM_ROW_W(4)) u_dut (.clk_sys, .rstn, .clkEnable, .chipSelectN, .rowStrobeN, .colStrobeN,
        .writeEnableN, .bankSelect, .addressIn, .lowerByteMask, .upperByteMask, .dataIoIn, .dataIoOut, .dataIoOe,
        .bankOpen, .modeReg, .extModeReg, .powerState);

    sdrci_ctrl_model u_ctrl (.clk_sys, .dataIoOut, .dataIoOe, .clkEnable, .chipSelectN, .rowStrobeN, .colStrobeN,
        .writeEnableN, .bankSelect, .addressIn, .lowerByteMask, .upperByteMask, .dataIoIn);

    // Comparison with counting
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Write burst of four with per-beat masks, tracked in the expected array
    task automatic wr(input logic [1:0] ba, input logic [11:0] a, input logic [3:0][15:0] d, input logic [3:0][1:0] m);
        logic [2:0] c;
        for (int i = 0; i < 4; i++) begin
            u_ctrl.cmd(i == 0 ? `SDRCI_CMD_WR : `SDRCI_CMD_NOP, ba, a, d[i], 1'b1, m[i]);
            c = {a[2], a[1:0] + 2'(i)};
            if (!m[i][0]) expMem[ba][c][7:0] = d[i][7:0];
            if (!m[i][1]) expMem[ba][c][15:8] = d[i][15:8];
        end
    endtask

    // Read burst of four, CL 2: word j shows three calls after its mask
    task automatic rd(input logic [1:0] ba, input logic [11:0] a, input logic [3:0][1:0] m);
        logic [2:0]  c;
        logic [15:0] lm;
        for (int i = 0; i < 8; i++) begin
            u_ctrl.cmd(i == 0 ? `SDRCI_CMD_RD : `SDRCI_CMD_NOP, ba, a, 16'h0000, 1'b0, i < 4 ? m[i % 4] : 2'h0);
            #1;
            if (i >= 3 && i < 7) begin
                c = {a[2], a[1:0] + 2'(i - 3)};
                lm = {{8{~m[i - 3][1]}}, {8{~m[i - 3][0]}}};
                chk("lane enable", {14'h0, ~m[i - 3]}, {14'h0, dataIoOe});
                chk("read word", expMem[ba][c] & lm, dataIoOut & lm);
            end
        end
        chk("lanes released", 16'h0000, {14'h0, dataIoOe});
    endtask

    // Hang guard, far beyond the expected run of about 10,070 cycles
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        chk("bank open after reset", 16'h0000, {12'h0, bankOpen});
        chk("power after reset", {12'h0, PW_RUN}, {12'h0, powerState});
        repeat (10000) u_ctrl.cmd(`SDRCI_CMD_NOP);
        u_ctrl.cmd(`SDRCI_CMD_PRE, 2'h0, 12'h400);
        u_ctrl.cmd(`SDRCI_CMD_REF);
        u_ctrl.cmd(`SDRCI_CMD_REF);
        u_ctrl.cmd(`SDRCI_CMD_LMR, 2'h0, 12'h022);
        u_ctrl.cmd(`SDRCI_CMD_LMR, 2'h2, 12'h015);
        u_ctrl.cmd(`SDRCI_CMD_LMR, 2'h1, 12'hFFF);
        u_ctrl.cmd(`SDRCI_CMD_ACT, 2'h0, 12'h001, 16'h0000, 1'b0, 2'h0, 1'b1, 1'b1);
        u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("mode register", 16'h0022, {4'h0, modeReg});
        chk("extended register", 16'h0015, {4'h0, extModeReg});
        chk("bank open, deselected", 16'h0000, {12'h0, bankOpen});
        u_ctrl.cmd(`SDRCI_CMD_ACT, 2'h0, 12'h001);
        u_ctrl.cmd(`SDRCI_CMD_ACT, 2'h1, 12'h002);
        u_ctrl.cmd(`SDRCI_CMD_LMR, 2'h0, 12'h033);
        u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("bank open", 16'h0003, {12'h0, bankOpen});
        chk("mode load refused", 16'h0022, {4'h0, modeReg});
        wr(2'h0, 12'h004, 64'hA3A3_A2A2_A1A1_A0A0, 8'h00);
        wr(2'h0, 12'h006, 64'hB3B3_B2B2_B1B1_B0B0, 8'hC4);
        rd(2'h0, 12'h004, 8'h08);
        wr(2'h1, 12'h400, 64'hC3C3_C2C2_C1C1_C0C0, 8'h00);
        rd(2'h0, 12'h004, 8'h00);
        chk("auto precharge", 16'h0001, {12'h0, bankOpen});
        u_ctrl.cmd(`SDRCI_CMD_ACT, 2'h3, 12'h000);
        u_ctrl.cmd(`SDRCI_CMD_PRE, 2'h0, 12'h000);
        u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("single precharge", 16'h0008, {12'h0, bankOpen});
        u_ctrl.cmd(`SDRCI_CMD_PRE, 2'h1, 12'h400);
        u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("all precharge", 16'h0000, {12'h0, bankOpen});
        for (int i = 0; i < 3; i++) begin
            u_ctrl.cmd(pwrCmd[i], 2'h0, 12'h000, 16'h0000, 1'b0, 2'h0, 1'b0);
            u_ctrl.cmd(`SDRCI_CMD_NOP, 2'h0, 12'h000, 16'h0000, 1'b0, 2'h0, 1'b0);
            #1;
            chk("low power state", {12'h0, pwrExp[i]}, {12'h0, powerState});
            u_ctrl.cmd(`SDRCI_CMD_NOP);
            u_ctrl.cmd(`SDRCI_CMD_NOP);
            #1;
            chk("power exit", {12'h0, PW_RUN}, {12'h0, powerState});
        end
        // Full page at latency three, cut by burst terminate
        u_ctrl.cmd(`SDRCI_CMD_LMR, 2'h0, 12'h037);
        u_ctrl.cmd(`SDRCI_CMD_ACT, 2'h0, 12'h001);
        u_ctrl.cmd(`SDRCI_CMD_RD, 2'h0, 12'h004);
        u_ctrl.cmd(`SDRCI_CMD_BST);
        repeat (3) u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("latency three word", expMem[0][4], dataIoOut);
        chk("latency three lanes", 16'h0003, {14'h0, dataIoOe});
        repeat (2) u_ctrl.cmd(`SDRCI_CMD_NOP);
        #1;
        chk("terminated burst", 16'h0000, {14'h0, dataIoOe});
        summarize();
    end
endmodule
